// *** include/flash_ctrl_pkg.sv ***
// Package with the register map, field layout and carriers of the flash control registers.
// Behaviour
// - Control register one has a holding copy and a working copy, loaded by the key.
// - Reading the commit address returns the monitor of the working copy.
// - With the disable pattern committed, command writes and toggle reads are dropped.
// - Reset sets the write-protect mode field to the disable pattern.
// - Committing protection rejects later commands but never aborts a running one.
// - Only the key byte written to the commit register applies the holding copy.
// - Flash area zero committed gives standard data-area mapping.
// - Flash area binary ten maps the upper code area onto the data area.
// - Boot ROM hidden or shown by its bit in MCU mode, always shown serially.
// - In serial programming mode the monitored boot ROM bit reads one.
// - The monitored write-protect bit is one only with the enable pattern committed.
// - Monitor bits seven and six always read zero.
// - Standby bit writes are accepted only from code running in RAM.
// - Flash access with the standby bit set raises a flash standby reset.
// - The standby control register reads as all zeros.
// - Serially, the clock pin input gate bit disables or enables that pin's input.
// - Serially, the general gate bit controls all ports but the serial pins.
// - In MCU mode the gating register does nothing, inputs stay enabled, reads zero.
// - Serially, after reset, all ports but receive and transmit stay disabled.
package flash_ctrl_pkg;

  localparam logic [15:0] ctrl_one_addr = 16'h0fd0;
  localparam logic [15:0] commit_addr = 16'h0fd1;
  localparam logic [15:0] monitor_addr = 16'h0fd1;
  localparam logic [15:0] standby_addr = 16'h0fd2;
  localparam logic [15:0] gating_addr = 16'h0fd3;

  localparam logic [7:0] ctrl_one_reset = 8'h40;
  localparam logic [7:0] monitor_reset = 8'h00;
  localparam logic [7:0] gating_reset = 8'h00;
  localparam logic [7:0] commit_key = 8'hd5;

  localparam logic [2:0] wp_disable = 3'h2;
  localparam logic [2:0] wp_enable = 3'h5;
  localparam logic [1:0] area_standard = 2'h0;
  localparam logic [1:0] area_code_remap = 2'h2;

  localparam int mon_wp_pos = 5;
  localparam int mon_boot_pos = 4;
  localparam int standby_pos = 0;
  localparam int gate_general_pos = 0;
  localparam int gate_sclk_pos = 1;

  // Field order matches the bit order of control register one, high to low.
  typedef struct packed {
    logic [2:0] wp_mode;
    logic boot_map;
    logic [1:0] flash_area;
    logic [1:0] rom_sel;
  } ctrl_one_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } flash_cmd_s;

endpackage

// *** src/flash_control_registers.sv ***
// Flash control register bank: double-buffered control, monitor, standby and port gating.
`timescale 1ns/100ps
`default_nettype none

module flash_control_registers (
  input wire logic ref_clk, // System clock, 40 MHz.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic [15:0] addr, // Register address.
  input wire logic [7:0] wdata, // Register write data.
  input wire logic wr, // Write strobe, one cycle.
  input wire logic rd, // Read strobe, one cycle.
  output logic [7:0] rdata, // Read data, valid the cycle after rd.
  input wire logic serial_prom_pin, // Mode pin, high selects serial programming mode.
  input wire logic exec_from_ram, // Current instruction was fetched from RAM.
  input wire logic flash_access, // CPU fetch, read or write to the flash this cycle.
  input wire logic standby_clear, // Interrupt vector fetched from flash clears standby.
  input wire logic cmd_valid_in, // CPU command write towards the flash.
  input wire flash_ctrl_pkg::flash_cmd_s cmd_in, // Address and data of that write.
  input wire logic toggle_in, // CPU toggle status read towards the flash.
  output logic cmd_valid_out, // Command write passed on to the flash engine.
  output flash_ctrl_pkg::flash_cmd_s cmd_out, // Address and data passed on.
  output logic toggle_out, // Toggle read passed on to the flash engine.
  output logic cmd_enable, // Command execution allowed by the working copy.
  output logic boot_rom_show, // Boot ROM mapped into the low code and data area.
  output logic [1:0] flash_area, // Working flash area select.
  output logic code_remap, // Upper code area mirrored into the data area.
  output logic [1:0] rom_select, // Working ROM select field.
  output logic serial_mode, // Filtered serial programming mode.
  output logic standby_active, // Flash standby bit is set.
  output logic standby_reset, // One-cycle flash standby reset request.
  output logic sclk_input_en, // Serial clock pin input enable.
  output logic port_input_en // Enable for all ports but the serial pins.
);

  // Mode pin filter: three flops, a change counts when the second and third agree.
  // The pin is asynchronous to ref_clk, so only the filtered value is used anywhere.
  logic mode_s1_q;
  logic mode_s2_q;
  logic mode_s3_q;
  logic mode_q;
  logic mode_d;

  always_comb begin
    mode_d = mode_q;
    if (mode_s2_q == mode_s3_q) begin
      mode_d = mode_s3_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
      mode_s3_q <= 1'b0;
      mode_q <= 1'b0;
    end else begin
      mode_s1_q <= serial_prom_pin;
      mode_s2_q <= mode_s1_q;
      mode_s3_q <= mode_s2_q;
      mode_q <= mode_d;
    end
  end

  // Register decode used by both the write and the read paths.
  function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
    hit = (a == target);
  endfunction

  // Write-protect decode shared by the monitor, the command gate and the enable output.
  function automatic logic wp_allows(input logic [2:0] mode);
    wp_allows = (mode == flash_ctrl_pkg::wp_enable);
  endfunction

  // Control register one: holding copy written by software, working copy loaded by the key.
  flash_ctrl_pkg::ctrl_one_s hold_q;
  flash_ctrl_pkg::ctrl_one_s hold_d;

  always_comb begin
    hold_d = hold_q;
    if (wr && hit(addr, flash_ctrl_pkg::ctrl_one_addr)) begin
      hold_d = flash_ctrl_pkg::ctrl_one_s'(wdata);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hold_q <= flash_ctrl_pkg::ctrl_one_s'(flash_ctrl_pkg::ctrl_one_reset);
    end else begin
      hold_q <= hold_d;
    end
  end

  // Working copy: the mapping and the command gate follow only this copy.
  flash_ctrl_pkg::ctrl_one_s work_q;
  flash_ctrl_pkg::ctrl_one_s work_d;
  logic commit_ok;

  always_comb begin
    work_d = work_q;
    commit_ok = wr && hit(addr, flash_ctrl_pkg::commit_addr)
                && (wdata == flash_ctrl_pkg::commit_key);
    // Any other commit value is reserved and simply leaves the working copy alone.
    if (commit_ok) begin
      work_d = hold_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      work_q <= flash_ctrl_pkg::ctrl_one_s'(flash_ctrl_pkg::ctrl_one_reset);
    end else begin
      work_q <= work_d;
    end
  end

  // Standby control: only code running from RAM may write the bit.
  logic standby_q;
  logic standby_d;

  always_comb begin
    standby_d = standby_q;
    if (wr && hit(addr, flash_ctrl_pkg::standby_addr) && exec_from_ram) begin
      standby_d = wdata[flash_ctrl_pkg::standby_pos];
    end
    // The interrupt clear wins over a same-cycle write so the vector read is safe.
    if (standby_clear) begin
      standby_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      standby_q <= 1'b0;
    end else begin
      standby_q <= standby_d;
    end
  end

  // Standby reset request: one pulse for each flash access made while the bit is set.
  logic sreset_q;
  logic sreset_d;

  always_comb begin
    sreset_d = standby_q && flash_access;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sreset_q <= 1'b0;
    end else begin
      sreset_q <= sreset_d;
    end
  end

  // Port input gating: stored only in serial programming mode.
  logic gate_general_q;
  logic gate_general_d;
  logic gate_sclk_q;
  logic gate_sclk_d;

  always_comb begin
    gate_general_d = gate_general_q;
    gate_sclk_d = gate_sclk_q;
    if (wr && hit(addr, flash_ctrl_pkg::gating_addr) && mode_q) begin
      gate_general_d = wdata[flash_ctrl_pkg::gate_general_pos];
      gate_sclk_d = wdata[flash_ctrl_pkg::gate_sclk_pos];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gate_general_q <= flash_ctrl_pkg::gating_reset[flash_ctrl_pkg::gate_general_pos];
      gate_sclk_q <= flash_ctrl_pkg::gating_reset[flash_ctrl_pkg::gate_sclk_pos];
    end else begin
      gate_general_q <= gate_general_d;
      gate_sclk_q <= gate_sclk_d;
    end
  end

  // Read path: data appear in the cycle after the strobe and read zero otherwise.
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] monitor;

  always_comb begin
    monitor = flash_ctrl_pkg::monitor_reset;
    monitor[flash_ctrl_pkg::mon_wp_pos] = wp_allows(work_q.wp_mode);
    monitor[flash_ctrl_pkg::mon_boot_pos] = work_q.boot_map || mode_q;
    monitor[3:2] = work_q.flash_area;
    monitor[1:0] = work_q.rom_sel;
    rdata_d = 8'h00;
    if (rd) begin
      if (hit(addr, flash_ctrl_pkg::ctrl_one_addr)) begin
        rdata_d = hold_q;
      end else if (hit(addr, flash_ctrl_pkg::monitor_addr)) begin
        rdata_d = monitor;
      end else if (hit(addr, flash_ctrl_pkg::standby_addr)) begin
        rdata_d = 8'h00;
      end else if (hit(addr, flash_ctrl_pkg::gating_addr) && mode_q) begin
        rdata_d[flash_ctrl_pkg::gate_general_pos] = gate_general_q;
        rdata_d[flash_ctrl_pkg::gate_sclk_pos] = gate_sclk_q;
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Command gate: new command writes and toggle reads pass only with commands enabled.
  // Nothing here reaches into the flash engine, so a sequence in flight runs to its end.
  logic enabled;
  logic cmd_valid_q;
  logic cmd_valid_d;
  logic toggle_q;
  logic toggle_d;

  always_comb begin
    enabled = wp_allows(work_q.wp_mode);
    cmd_valid_d = cmd_valid_in && enabled;
    toggle_d = toggle_in && enabled;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_valid_q <= 1'b0;
      toggle_q <= 1'b0;
    end else begin
      cmd_valid_q <= cmd_valid_d;
      toggle_q <= toggle_d;
    end
  end

  // Command payload: holds the last passed command, so a blocked write cannot alter it.
  flash_ctrl_pkg::flash_cmd_s cmd_q;
  flash_ctrl_pkg::flash_cmd_s cmd_d;

  always_comb begin
    cmd_d = cmd_q;
    if (cmd_valid_d) begin
      cmd_d = cmd_in;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_q <= '0;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  // Command enable output, registered from the next working state.
  logic enable_q;
  logic enable_d;

  always_comb begin
    enable_d = wp_allows(work_d.wp_mode);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
    end
  end

  // Memory map outputs, registered from the next working state.
  logic boot_q;
  logic boot_d;
  logic [1:0] area_q;
  logic [1:0] area_d;
  logic remap_q;
  logic remap_d;
  logic [1:0] romsel_q;
  logic [1:0] romsel_d;

  always_comb begin
    boot_d = work_d.boot_map || mode_d;
    area_d = work_d.flash_area;
    // Zero keeps the data area on its own flash; ten mirrors the upper code area.
    remap_d = (work_d.flash_area == flash_ctrl_pkg::area_code_remap);
    romsel_d = work_d.rom_sel;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      boot_q <= 1'b0;
      area_q <= flash_ctrl_pkg::area_standard;
      remap_q <= 1'b0;
      romsel_q <= 2'h0;
    end else begin
      boot_q <= boot_d;
      area_q <= area_d;
      remap_q <= remap_d;
      romsel_q <= romsel_d;
    end
  end

  // Port input enables: the gating bits act only in serial programming mode.
  logic sclk_en_q;
  logic sclk_en_d;
  logic port_en_q;
  logic port_en_d;

  always_comb begin
    sclk_en_d = mode_d ? gate_sclk_d : 1'b1;
    port_en_d = mode_d ? gate_general_d : 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_en_q <= 1'b1;
      port_en_q <= 1'b1;
    end else begin
      sclk_en_q <= sclk_en_d;
      port_en_q <= port_en_d;
    end
  end

  assign rdata = rdata_q;
  assign cmd_valid_out = cmd_valid_q;
  assign cmd_out = cmd_q;
  assign toggle_out = toggle_q;
  assign cmd_enable = enable_q;
  assign boot_rom_show = boot_q;
  assign flash_area = area_q;
  assign code_remap = remap_q;
  assign rom_select = romsel_q;
  assign serial_mode = mode_q;
  assign standby_active = standby_q;
  assign standby_reset = sreset_q;
  assign sclk_input_en = sclk_en_q;
  assign port_input_en = port_en_q;

endmodule

`default_nettype wire

// *** test/flash_control_registers_chk.sv ***
// Checker of the port-level timing of the flash control register bank.
`timescale 1ns/100ps
`default_nettype none

module flash_control_registers_chk (
  input wire logic ref_clk, // Clock.
  input wire logic rstn, // Reset, active low.
  input wire logic [15:0] addr, // Address.
  input wire logic rd, // Read strobe.
  input wire logic [7:0] rdata, // Read data.
  input wire logic cmd_valid_in, // Command in.
  input wire flash_ctrl_pkg::flash_cmd_s cmd_in, // Command payload in.
  input wire logic cmd_valid_out, // Command out.
  input wire flash_ctrl_pkg::flash_cmd_s cmd_out, // Command payload out.
  input wire logic toggle_out, // Toggle out.
  input wire logic cmd_enable, // Commands allowed.
  input wire logic boot_rom_show, // Boot ROM shown.
  input wire logic serial_mode, // Serial mode.
  input wire logic flash_access, // Flash access.
  input wire logic standby_active, // Standby set.
  input wire logic standby_reset, // Standby reset.
  input wire logic sclk_input_en, // Clock pin input enable.
  input wire logic port_input_en // Port input enable.
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  chk_cmd_pass: assert property (
    cmd_valid_in && cmd_enable |=> cmd_valid_out && cmd_out == $past(cmd_in))
    else $error("enabled command was not passed on");
  chk_cmd_block: assert property (
    !cmd_enable |=> !cmd_valid_out && !toggle_out)
    else $error("command passed while protected");
  chk_mon_top: assert property (
    rd && addr == flash_ctrl_pkg::monitor_addr |=> rdata[7:6] == 2'h0)
    else $error("monitor top bits not zero");
  chk_mon_wp: assert property (
    rd && addr == flash_ctrl_pkg::monitor_addr |=> rdata[5] == $past(cmd_enable))
    else $error("monitor protect bit wrong");
  chk_stby_read: assert property (
    rd && addr == flash_ctrl_pkg::standby_addr |=> rdata == 8'h00)
    else $error("standby register read not zero");
  chk_boot_serial: assert property (
    serial_mode && $past(serial_mode) |-> boot_rom_show)
    else $error("boot ROM hidden in serial mode");
  chk_mcu_gates: assert property (
    !serial_mode && !$past(serial_mode) |-> sclk_input_en && port_input_en)
    else $error("port input gated in MCU mode");
  chk_stby_pulse: assert property (
    flash_access && standby_active |=> standby_reset)
    else $error("no standby reset on flash access");
endmodule

bind flash_control_registers flash_control_registers_chk u_chk (.ref_clk, .rstn, .addr, .rd,
  .rdata, .cmd_valid_in, .cmd_in, .cmd_valid_out, .cmd_out, .toggle_out, .cmd_enable,
  .boot_rom_show, .serial_mode, .flash_access, .standby_active, .standby_reset,
  .sclk_input_en, .port_input_en);

`default_nettype wire

// *** test/flash_control_registers_tb.sv ***
// Self-checking testbench of the flash control register bank.
`timescale 1ns/100ps
`default_nettype none

module flash_control_registers_tb;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0, serial_prom_pin = 1'b0, exec_from_ram = 1'b0;
  logic flash_access = 1'b0, standby_clear = 1'b0, cmd_valid_in = 1'b0, toggle_in = 1'b0;
  flash_ctrl_pkg::flash_cmd_s cmd_in = '0, cmd_out, last = '0;
  logic [7:0] rdata, hold = 8'h40, work = 8'h40, d;
  logic cmd_valid_out, toggle_out, cmd_enable, boot_rom_show, code_remap, serial_mode;
  logic standby_active, standby_reset, sclk_input_en, port_input_en, stb = 1'b0, smode = 1'b0;
  logic [1:0] flash_area, rom_select, gate = 2'h0;
  int n_errors = 0, check_count = 0;

  always #12.5 ref_clk = ~ref_clk;

  flash_control_registers dut (.ref_clk, .rstn, .addr, .wdata, .wr, .rd, .rdata,
    .serial_prom_pin, .exec_from_ram, .flash_access, .standby_clear, .cmd_valid_in, .cmd_in,
    .toggle_in, .cmd_valid_out, .cmd_out, .toggle_out, .cmd_enable, .boot_rom_show,
    .flash_area, .code_remap, .rom_select, .serial_mode, .standby_active, .standby_reset,
    .sclk_input_en, .port_input_en);

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The model updates only after the strobe edge, mirroring when the write is taken.
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] v, input logic ram);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    exec_from_ram <= ram;
    @(posedge ref_clk);
    wr <= 1'b0;
    if (a == 16'h0fd0) hold = v;
    if (a == 16'h0fd1 && v == 8'hd5) work = hold;
    if (a == 16'h0fd2 && ram) stb = v[0];
    if (a == 16'h0fd3 && smode) gate = v[1:0];
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask

  function automatic logic [7:0] mon();
    return {2'h0, work[7:5] == 3'h5, work[4] | smode, work[3:0]};
  endfunction

  // Two edges of settling cover outputs that are derived from other registers.
  task automatic out_chk();
    repeat (2) @(posedge ref_clk);
    #1 chk({serial_mode, cmd_enable, boot_rom_show, flash_area, code_remap, rom_select,
      standby_active, sclk_input_en, port_input_en}, {smode, work[7:5] == 3'h5,
      work[4] | smode, work[3:2], work[3:2] == 2'h2, work[1:0], stb, !smode | gate[1],
      !smode | gate[0]});
  endtask

  task automatic cmd_try();
    flash_ctrl_pkg::flash_cmd_s c;
    c = 24'($urandom);
    @(posedge ref_clk);
    cmd_valid_in <= 1'b1;
    toggle_in <= 1'b1;
    cmd_in <= c;
    @(posedge ref_clk);
    cmd_valid_in <= 1'b0;
    toggle_in <= 1'b0;
    if (work[7:5] == 3'h5) last = c;
    #1 chk({cmd_valid_out, toggle_out, cmd_out}, {{2{work[7:5] == 3'h5}}, last});
  endtask

  initial begin
    repeat (3000) @(posedge ref_clk);
    n_errors++;
    wrap_up();
  end

  initial begin
    void'($urandom(92274));
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    rd_chk(16'h0fd0, 8'h40);
    rd_chk(16'h0fd1, 8'h00);
    rd_chk(16'h0fd4, 8'h00);
    wr_reg(16'h0fd3, 8'h03, 1'b1);
    rd_chk(16'h0fd3, 8'h00);
    out_chk();
    repeat (10) begin
      d = {$urandom % 2 ? 3'h5 : 3'h2, 1'($urandom), $urandom % 2 ? 2'h2 : 2'h0, 2'($urandom)};
      wr_reg(16'h0fd0, d, 1'($urandom));
      rd_chk(16'h0fd0, hold);
      out_chk();
      wr_reg(16'h0fd1, 8'hd5 ^ 8'(1 + $urandom % 255), 1'b0);
      out_chk();
      wr_reg(16'h0fd1, 8'hd5, 1'b0);
      out_chk();
      rd_chk(16'h0fd1, mon());
      cmd_try();
    end
    wr_reg(16'h0fd2, 8'h01, 1'b0);
    out_chk();
    wr_reg(16'h0fd2, 8'h01, 1'b1);
    out_chk();
    rd_chk(16'h0fd2, 8'h00);
    @(posedge ref_clk);
    flash_access <= 1'b1;
    @(posedge ref_clk);
    flash_access <= 1'b0;
    #1 chk(standby_reset, 1'b1);
    @(posedge ref_clk);
    standby_clear <= 1'b1;
    @(posedge ref_clk);
    standby_clear <= 1'b0;
    stb = 1'b0;
    out_chk();
    @(posedge ref_clk);
    serial_prom_pin <= 1'b1;
    smode = 1'b1;
    repeat (8) @(posedge ref_clk);
    out_chk();
    rd_chk(16'h0fd1, mon());
    wr_reg(16'h0fd3, 8'h02, 1'b0);
    out_chk();
    rd_chk(16'h0fd3, 8'h02);
    wr_reg(16'h0fd3, 8'h01, 1'b0);
    out_chk();
    @(posedge ref_clk);
    serial_prom_pin <= 1'b0;
    smode = 1'b0;
    repeat (8) @(posedge ref_clk);
    out_chk();
    wrap_up();
  end
endmodule

`default_nettype wire
